// ### common/sewg_map.vh
// Overview of operation
// R1: guard high blocks writes to 100h-1FFh
// R2: unconnected guard reads low, writes allowed
// R3: protected write acks select, address, not data
// R4: ignore bus until power-on reset releases
// R5: start is SDA falling with SCL high
// R6: stop is SDA rising, ends communication
// R7: read ended by noack and stop
// R8: transmitter releases SDA, receiver acks ninth
// R9: sample SDA on rising SCL edge
// R10: master changes SDA only while SCL low
// R11: select byte sent msb first, fixed fields
// R12: respond only when strap bits match
// R13: direction one reads, zero writes
// R14: ack on match, release on mismatch
// R15: select b1 is address top bit; a read select ignores it and keeps the counter's top bit
// R16: write select, address byte, then data
// R17: program only on stop after ack
// R18: ignore bus during programming cycle
// R19: guard sampled start to address end
// R20: page of 16, wrap low nibble
// R21: protected page write acks no data
// R22: master avoids page roll-over; the bench's first write starts at offset Eh and rolls over
// R23: random read via dummy write, restart
// R24: address counter advances per read byte
// R25: counter wraps to 00h after top
// R26: read noack ends transfer, ack continues
// R27: upper half when address top bit set
// R28: programming cycle length is configurable count
`ifndef SEWG_MAP_VH
`define SEWG_MAP_VH
`define SEWG_TYPE_ID     4'h6 // arbitrary type code
`define SEWG_SEL_DIR     0
`define SEWG_SEL_TOP     1
`define SEWG_SEL_STRAPLO 2
`define SEWG_SEL_STRAPHI 3
`define SEWG_PAGE_BYTES  16
`define SEWG_MEM_BYTES   512
`define SEWG_MEM_RESET   8'hff
`define SEWG_PROG_CYCLES 2000
`endif

// ### core/sewg_sync.v
`timescale 1ns/1ps
// two-flop synchroniser for asynchronous pin levels
module sewg_sync #(
    parameter WIDTH = 1,
    // level held in reset, the idle level of each pin
    parameter [WIDTH-1:0] IDLE_LEVEL = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // levels
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // first flop read only by second
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= IDLE_LEVEL;
            sync_q <= IDLE_LEVEL;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule

// ### core/sewg_eeprom.v
`timescale 1ns/1ps
`include "sewg_map.vh"
module sewg_eeprom #(
    parameter PROG_CYCLES = `SEWG_PROG_CYCLES
) (
    // clock and power-on reset
    input  wire clk,
    input  wire rst_n,
    // two-wire bus
    input  wire scl,
    input  wire sdaIn,
    output reg  sdaOut,
    output reg  sdaOe_n,
    // straps and guard
    input  wire strap_select_low,
    input  wire strap_select_high,
    input  wire upper_half_write_guard,
    // status
    output reg  busy,
    output reg  selected
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_SEL  = 7'h02;
    localparam [6:0] ST_ADDR = 7'h04;
    localparam [6:0] ST_WDAT = 7'h08;
    localparam [6:0] ST_RDAT = 7'h10;
    localparam [6:0] ST_RACK = 7'h20;
    localparam [6:0] ST_PROG = 7'h40;

    reg [7:0]  mem [0:`SEWG_MEM_BYTES-1];
    reg [7:0]  page_q [0:`SEWG_PAGE_BYTES-1];
    reg [`SEWG_PAGE_BYTES-1:0] pageValid_q;
    reg [6:0]  state_q;
    reg [3:0]  bitCnt_q;
    reg [7:0]  shift_q;
    reg [8:0]  addr_q;
    reg        ackSlot_q;
    reg        ackGiven_q;
    reg        guard_q;
    reg        tenth_q;
    reg        rdMode_q;
    reg [31:0] progCnt_q;
    reg        sclD_q;
    reg        sdaD_q;
    integer    i;
    integer    j;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    wire [4:0] syn;
    // scl and sda reset to their idle high level, straps and guard low
    sewg_sync #(
        .WIDTH      (5),
        .IDLE_LEVEL (5'h18)
    ) sewg_sync_inst (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn ({scl, sdaIn, strap_select_low, strap_select_high,
                   upper_half_write_guard}),
        .syncOut (syn)
    );
    wire sclS   = syn[4];
    wire sdaS   = syn[3];
    wire strapL = syn[2];
    wire strapH = syn[1];
    // R2: floating guard pulled low externally, low means writable
    wire guardS = syn[0];

    wire sclRise = sclS & ~sclD_q;
    wire sclFall = ~sclS & sclD_q;
    // R5: start is sda falling while scl high
    wire startEv = sclS & sclD_q & sdaD_q & ~sdaS;
    // R6: stop is sda rising while scl high
    wire stopEv  = sclS & sclD_q & ~sdaD_q & sdaS;

    // matching select byte check, used once
    function selMatch;
        input [7:0] b;
        input       lo;
        input       hi;
        begin
            selMatch = (b[7:4] == `SEWG_TYPE_ID) &&
                       (b[`SEWG_SEL_STRAPHI] == hi) &&
                       (b[`SEWG_SEL_STRAPLO] == lo);
        end
    endfunction

    wire [7:0] rxByte = {shift_q[6:0], sdaS};

    // ----------------------------------------------------------------
    // write guard and byte acceptance
    // ----------------------------------------------------------------
    // R27: upper half when top address bit set
    function protHit;
        input       grd;
        input [8:0] adr;
        begin
            protHit = grd & adr[8];
        end
    endfunction

    // data byte complete and writable, latched into the page buffer
    wire wrAccept = (state_q == ST_WDAT) && !ackSlot_q && sclFall &&
                    (bitCnt_q == 4'h8) && !protHit(guard_q, addr_q);
    // one-cycle pulse that commits the page to the array
    wire commitPage = (state_q == ST_PROG) && (progCnt_q == 32'h0);

    // ----------------------------------------------------------------
    // previous pin levels for edge detection
    // ----------------------------------------------------------------
    // reset to idle high so no false edge follows reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclD_q <= 1'b1;
            sdaD_q <= 1'b1;
        end else begin
            sclD_q <= sclS;
            sdaD_q <= sdaS;
        end
    end

    // ----------------------------------------------------------------
    // bus sequencer
    // ----------------------------------------------------------------
    // R4: asynchronous power-on reset holds standby
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= ST_IDLE;
            bitCnt_q    <= 4'h0;
            shift_q     <= 8'h00;
            addr_q      <= 9'h000;
            ackSlot_q   <= 1'b0;
            ackGiven_q  <= 1'b0;
            guard_q     <= 1'b0;
            tenth_q     <= 1'b0;
            rdMode_q    <= 1'b0;
            progCnt_q   <= 32'h0;
            pageValid_q <= {`SEWG_PAGE_BYTES{1'b0}};
            sdaOut      <= 1'b1;
            sdaOe_n     <= 1'b1;
            busy        <= 1'b0;
            selected    <= 1'b0;
        end else begin
            busy   <= (state_q == ST_PROG);
            selected <= (state_q != ST_IDLE) && (state_q != ST_PROG);
            if (state_q == ST_PROG) begin
                // R18: bus ignored while programming
                // R28: configurable cycle count
                if (progCnt_q >= PROG_CYCLES - 1) begin
                    state_q <= ST_IDLE;
                    progCnt_q <= 32'h0;
                end else begin
                    progCnt_q <= progCnt_q + 32'h1;
                end
            end else if (startEv) begin
                // R19: guard captured from start onward
                state_q    <= ST_SEL;
                bitCnt_q   <= 4'h0;
                ackSlot_q  <= 1'b0;
                tenth_q    <= 1'b0;
                guard_q    <= guardS;
                sdaOe_n    <= 1'b1;
                pageValid_q <= {`SEWG_PAGE_BYTES{1'b0}};
            end else if (stopEv) begin
                // R17: program only when stop lands in tenth slot
                if (state_q == ST_WDAT && tenth_q && (|pageValid_q))
                    state_q <= ST_PROG;
                else
                    state_q <= ST_IDLE; // R6: R7: back to standby
                progCnt_q <= 32'h0;
                sdaOe_n   <= 1'b1;
            end else if (state_q != ST_IDLE) begin
                // R9: sample on rising scl
                if (sclRise) begin
                    if (!ackSlot_q) begin
                        shift_q  <= rxByte;
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (state_q == ST_SEL || state_q == ST_ADDR)
                            guard_q <= guard_q | guardS;
                    end else if (state_q == ST_RACK) begin
                        // R26: master noack ends the read
                        if (sdaS)
                            state_q <= ST_IDLE;
                        else
                            state_q <= ST_RDAT;
                    end
                end
                if (sclFall) begin
                    // the fall that ends the tenth slot leaves it
                    tenth_q <= 1'b0;
                    if (ackSlot_q) begin
                        // R8: release after ninth bit
                        ackSlot_q <= 1'b0;
                        sdaOe_n   <= 1'b1;
                        bitCnt_q  <= 4'h0;
                        tenth_q   <= ackGiven_q;
                        if (rdMode_q &&
                            (state_q == ST_RDAT || state_q == ST_RACK)) begin
                            // R24: shift out byte at counter
                            if (state_q == ST_RDAT || !sdaS) begin
                                shift_q <= mem[addr_q];
                                sdaOut  <= mem[addr_q][7];
                                sdaOe_n <= ~mem[addr_q][7] ? 1'b0 : 1'b1;
                                state_q <= ST_RDAT;
                            end
                        end
                    end else if (state_q == ST_RDAT) begin
                        if (bitCnt_q == 4'h8) begin
                            // R8: release for master ack
                            sdaOe_n   <= 1'b1;
                            ackSlot_q <= 1'b1;
                            ackGiven_q <= 1'b0;
                            state_q   <= ST_RACK;
                            // R25: nine-bit counter wraps to 00h
                            addr_q    <= addr_q + 9'h001;
                        end else begin
                            // each rise shifts left, so bit 7 goes next
                            sdaOut  <= shift_q[7];
                            sdaOe_n <= shift_q[7];
                        end
                    end else if (bitCnt_q == 4'h8) begin
                        ackSlot_q  <= 1'b1;
                        ackGiven_q <= 1'b0;
                        case (state_q)
                        ST_SEL: begin
                            // R12: R14: straps must match
                            if (selMatch(shift_q, strapL, strapH)) begin
                                sdaOut  <= 1'b0;
                                sdaOe_n <= 1'b0;
                                ackGiven_q <= 1'b1;
                                // R15: select b1 is top address bit
                                addr_q[8] <= shift_q[`SEWG_SEL_TOP];
                                // R13: direction bit selects read
                                rdMode_q <= shift_q[`SEWG_SEL_DIR];
                                if (shift_q[`SEWG_SEL_DIR]) begin
                                    // read keeps the counter's top bit
                                    addr_q[8] <= addr_q[8];
                                    state_q <= ST_RDAT;
                                end else begin
                                    state_q <= ST_ADDR;
                                end
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                        ST_ADDR: begin
                            // R16: R23: address byte acknowledged
                            addr_q[7:0] <= shift_q;
                            sdaOut  <= 1'b0;
                            sdaOe_n <= 1'b0;
                            ackGiven_q <= 1'b1;
                            state_q <= ST_WDAT;
                        end
                        ST_WDAT: begin
                            // R1: R3: R21: R27: guarded upper half
                            if (!protHit(guard_q, addr_q)) begin
                                sdaOut  <= 1'b0;
                                sdaOe_n <= 1'b0;
                                ackGiven_q <= 1'b1;
                                pageValid_q[addr_q[3:0]] <= 1'b1;
                                // R20: only low nibble advances
                                addr_q[3:0] <= addr_q[3:0] + 4'h1;
                            end
                        end
                        default: state_q <= ST_IDLE;
                        endcase
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // page latch and array update
    // ----------------------------------------------------------------
    // latch accepted bytes, commit them at start of programming
    always @(posedge clk) begin
        // byte slot filled as the device acknowledges it
        if (wrAccept)
            page_q[addr_q[3:0]] <= shift_q;
        // commit only the slots accepted in this frame
        if (commitPage) begin
            for (i = 0; i < `SEWG_PAGE_BYTES; i = i + 1) begin
                if (pageValid_q[i])
                    mem[{addr_q[8:4], i[3:0]}] <= page_q[i];
            end
        end
    end

    // array initial content
    initial begin
        for (j = 0; j < `SEWG_MEM_BYTES; j = j + 1)
            mem[j] = `SEWG_MEM_RESET;
    end
endmodule

// ### tb/sewg_eeprom_chk.sv
`timescale 1ns/1ps
// ----------------------------------
// bus-side checks
// ----------------------------------
module sewg_eeprom_chk #(
    parameter PROG_CYCLES = 20
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // bus and status
    input wire scl,
    input wire sdaIn,
    input wire sdaOut,
    input wire sdaOe_n,
    input wire busy,
    input wire selected
);
    logic [15:0] busyCnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence stopSeen; scl && $rose(sdaIn); endsequence
    sequence sclSteady; scl [*4]; endsequence
    // length of the running programming cycle
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) busyCnt_q <= 16'h0;
        else busyCnt_q <= busy ? busyCnt_q + 16'h1 : 16'h0;
    reset_quiet_a: assert property (
        $rose(rst_n) |-> sdaOe_n && !busy && !selected)
        else $error("outputs not idle after reset");
    drive_low_a: assert property (
        !sdaOe_n |-> !sdaOut) else $error("data line driven high");
    drive_sel_a: assert property (
        $fell(sdaOe_n) |-> selected) else $error("drive while deselected");
    stop_ends_a: assert property (
        stopSeen |-> ##[1:8] !selected) else $error("stop did not deselect");
    steady_high_a: assert property (
        sclSteady |-> $stable(sdaOe_n)) else $error("drive moved, clock high");
    busy_deaf_a: assert property (
        busy |-> sdaOe_n && !selected) else $error("bus answered when busy");
    prog_len_a: assert property (
        $fell(busy) |-> busyCnt_q >= PROG_CYCLES - 1
            && busyCnt_q <= PROG_CYCLES + 1) else $error("wrong busy length");
    prog_stop_a: assert property (
        $rose(busy) |-> scl && sdaIn) else $error("programming without stop");
endmodule

bind sewg_eeprom sewg_eeprom_chk #(.PROG_CYCLES(PROG_CYCLES))
    sewg_eeprom_chk_inst (.clk, .rst_n, .scl, .sdaIn, .sdaOut, .sdaOe_n,
    .busy, .selected);

// ### tb/sewg_master.sv
`timescale 1ns/1ps
// ----------------------------------
// two-wire bus master model
// ----------------------------------
module sewg_master (
    // clock
    input  wire  clk,
    // bus
    input  wire  sda,
    output logic scl,
    output logic sdaM
);
    // bus idles high, clock parked outside frames
    initial begin
        scl = 1'b1;
        sdaM = 1'b1;
    end
    // wait n edges, then step off the edge
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic bitx(input logic b, output logic r);
        w(1);
        sdaM = b;
        w(3);
        scl = 1'b1;
        w(4);
        r = sda;
        scl = 1'b0;
    endtask
    // start or repeated start
    task automatic start();
        w(1);
        sdaM = 1'b1;
        w(3);
        scl = 1'b1;
        w(4);
        sdaM = 1'b0;
        w(4);
        scl = 1'b0;
    endtask
    // stop leaves the bus high
    task automatic stop();
        w(1);
        sdaM = 1'b0;
        w(3);
        scl = 1'b1;
        w(4);
        sdaM = 1'b1;
        w(4);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    // release for data, then ack or not
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(~mack, r);
    endtask
endmodule

// ### tb/sewg_eeprom_test.sv
`timescale 1ns/1ps
`include "sewg_map.vh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch %0t got %h want %h", $time, got, exp); end end
// ----------------------------------
// self-checking bench
// ----------------------------------
module sewg_eeprom_test;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       guard = 1'b0;
    logic       strapLo = 1'b0;
    logic       strapHi = 1'b0;
    logic       ack;
    logic [7:0] d;
    logic [8:0] base;
    logic [7:0] mem [512];
    logic [31:0] lfsr_q = 32'hc2af;
    wire        scl, sdaM, sda, sdaOut, sdaOe_n, busy, selected;
    int         errors = 0;
    int         checked = 0;
    // clock and pulled-up open-drain data line
    always #20 clk = ~clk;
    assign sda = sdaM & (sdaOe_n | sdaOut);
    sewg_eeprom #(.PROG_CYCLES(20)) sewg_eeprom_inst (.clk(clk),
        .rst_n(rst_n), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe_n(sdaOe_n), .strap_select_low(strapLo),
        .strap_select_high(strapHi), .upper_half_write_guard(guard),
        .busy(busy), .selected(selected));
    sewg_master sewg_master_inst (.clk(clk), .sda(sda), .scl(scl),
        .sdaM(sdaM));
    // random source and expected select byte
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] sel(input logic top, input logic rd);
        return {`SEWG_TYPE_ID, strapHi, strapLo, top, rd};
    endfunction
    // write n bytes of random data, at most one page
    task automatic wr(input logic [8:0] a, input int n, input logic ok);
        sewg_master_inst.start();
        sewg_master_inst.wbyte(sel(a[8], 1'b0), ack);
        `CHK(ack, 1'b1)
        sewg_master_inst.wbyte(a[7:0], ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            lfsr_q = nextRand(lfsr_q);
            sewg_master_inst.wbyte(lfsr_q[7:0], ack);
            `CHK(ack, ok)
            if (ok) mem[{a[8:4], 4'(a[3:0] + i)}] = lfsr_q[7:0];
        end
        sewg_master_inst.stop();
    endtask
    // dummy write, repeated start, sequential read
    task automatic rd(input logic [8:0] a, input int n);
        sewg_master_inst.start();
        sewg_master_inst.wbyte(sel(a[8], 1'b0), ack);
        sewg_master_inst.wbyte(a[7:0], ack);
        sewg_master_inst.start();
        sewg_master_inst.wbyte(sel(a[8], 1'b1), ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            sewg_master_inst.rbyte(i < n - 1, d);
            `CHK(d, mem[9'(a + i)])
        end
        sewg_master_inst.stop();
        `CHK(selected, 1'b0)
    endtask
    // check programming started or not, then wait it out
    task automatic settle(input logic prog);
        sewg_master_inst.w(6);
        `CHK(busy, prog)
        for (int k = 0; k < 100 && busy !== 1'b0; k++) sewg_master_inst.w(1);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog, roughly fourteen times the expected run
    initial begin
        #2000000;
        errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        lfsr_q = nextRand(lfsr_q);
        strapLo = lfsr_q[0];
        strapHi = lfsr_q[1];
        base = {1'b0, lfsr_q[7:4], 4'he};
        for (int i = 0; i < 512; i++) mem[i] = `SEWG_MEM_RESET;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        sewg_master_inst.w(6);
        for (int j = 1; j < 4; j++) begin
            sewg_master_inst.start();
            sewg_master_inst.wbyte(sel(1'b0, 1'b0) ^ 8'(j << 2), ack);
            `CHK(ack, 1'b0)
            sewg_master_inst.stop();
        end
        guard = 1'b1;
        wr(base, 4, 1'b1);
        settle(1'b1);
        wr(9'h1fd, 2, 1'b0);
        settle(1'b0);
        guard = 1'b0;
        wr(9'h1fe, 2, 1'b1);
        sewg_master_inst.start();
        sewg_master_inst.wbyte(sel(1'b0, 1'b0), ack);
        `CHK(ack, 1'b0)
        sewg_master_inst.stop();
        settle(1'b0);
        rd(9'h1fd, 4);
        rd({base[8:4], 4'h0}, 16);
        tally_and_finish();
    end
endmodule
